// File: logic/vagc_map.svh
// register offsets, field positions, reset values and timing figures of the video gain/offset control
`ifndef VAGC_MAP_SVH
`define VAGC_MAP_SVH
`define VAGC_A_INCFG 8'h05
`define VAGC_A_GAIN0 8'h06
`define VAGC_A_GAIN1 8'h07
`define VAGC_A_GAIN2 8'h08
`define VAGC_A_OFF0 8'h09
`define VAGC_A_OFF1 8'h0a
`define VAGC_A_OFF2 8'h0b
`define VAGC_A_FINE 8'h0c
`define VAGC_A_FILT 8'h0d
`define VAGC_A_LTA 8'h0e
`define VAGC_A_LTB 8'h0f
`define VAGC_A_PHASE 8'h10
`define VAGC_A_EXTCLP 8'h13
`define VAGC_A_STA 8'h14
`define VAGC_A_STB 8'h15
`define VAGC_A_SERVO 8'h17
`define VAGC_A_STATUS 8'h1c
`define VAGC_A_DAC0 8'h1d
`define VAGC_A_DAC1 8'h1e
`define VAGC_A_DAC2 8'h1f
`define VAGC_B_YUV 2
`define VAGC_B_COAST_CLP 5
`define VAGC_B_SERVO_OFF 0
`define VAGC_B_RANGE 0
`define VAGC_R_GAIN 8'h55
`define VAGC_R_OFF 8'h80
`define VAGC_R_FILT 8'h0e
`define VAGC_R_ZERO 8'h00
`define VAGC_R_STA 8'h08
`define VAGC_R_LTA 8'h20
`define VAGC_R_LTB 8'h03
`define VAGC_R_DAC 10'h200
`define VAGC_DAC_MAX 10'h3ff
`define VAGC_CHROMA_BLACK 8'h80
`define VAGC_PIX_SHIFT_BASE 3
`define VAGC_CLK_MHZ 250
`define VAGC_GAIN_TMO_MS 100
`endif

// File: logic/vagc_pkg.sv
// types shared by the video gain/offset control
package vagc_pkg;
	typedef enum logic [1:0] {SV_IDLE, SV_DELAY, SV_SAMPLE, SV_UPDATE} vagc_state_t;
	typedef struct packed {
		logic valid;
		logic [2:0][7:0] data;
	} vagc_pix_t;
	typedef struct packed {
		logic [2:0] bw_sel;
		logic [3:0] peak_sel;
		logic dac_half_range;
		logic [15:0] line_total_pixels;
		logic [5:0] phase;
	} vagc_analog_t;
endpackage : vagc_pkg

// File: logic/vagc_top.sv
// gain, filter, offset dac, black level servo and pixel clock setup of a triple video digitizer
// Behaviour
// - amplifier gain is 0.5 plus code over 170; unity at code 0x55.
// - a written gain code reaches the amplifier at the next clamp event or at the gain timeout.
// - lacking clamp events, a pending gain is applied after at most 100ms.
// - filter bits 3..1 pick one of eight bandwidths; bit 0 ignored.
// - filter bits 7..4 pick the peaking zero; zero disables peaking.
// - with servo active, offset registers add a digital offset to converter output.
// - servo disabled hands the dac to firmware: offset register plus two fine bits.
// - range bit halves the dac span, in both servo and manual modes.
// - manual offset step follows range bit; servo mode offset step is one LSB.
// - servo runs once per line after the sync trailing edge when enabled.
// - coast-clamp bit clear blocks servo triggering while the clock loop coasts.
// - servo waits the start-pixel count after the sync trailing edge.
// - servo averages a selected number of pixels and accumulates the result.
// - accumulator averages over a selected line count and steers the 10-bit dac.
// - pixel clock equals line rate times the two-register line total.
// - sampling point is one of 64 phase steps from the phase register.
// - three parallel 8-bit sample channels are delivered.
// - offset 0x80 gives black code 0x00; chroma in component mode gives 0x80.
// - each colour channel has its own 8-bit gain register.
//
// The address-and-strobe port was left to the implementer.
`include "vagc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module vagc_top #(
	parameter int unsigned GAIN_TMO_CYC = `VAGC_GAIN_TMO_MS * 1000 * `VAGC_CLK_MHZ,
	parameter int unsigned TMO_W = $clog2(GAIN_TMO_CYC + 1)
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic hsync_in,
	input wire logic coast_in,
	input wire logic ext_clamp_in,
	input wire vagc_pkg::vagc_pix_t adc_in,
	output vagc_pkg::vagc_pix_t pix_out,
	output logic [2:0][7:0] gain_code_value,
	output logic [2:0][9:0] offset_dac,
	output vagc_pkg::vagc_analog_t analog_cfg
);
	// register file
	logic [2:0][7:0] gain_r, gain_nxt, off_r, off_nxt;
	logic [7:0] fine_r, fine_nxt, filt_r, filt_nxt, lta_r, lta_nxt, ltb_r, ltb_nxt;
	logic [7:0] phase_r, phase_nxt, incfg_r, incfg_nxt, extclp_r, extclp_nxt;
	logic [7:0] sta_r, sta_nxt, stb_r, stb_nxt, servo_r, servo_nxt, rdata_r, rdata_nxt;
	logic gpend_r, gpend_nxt;
	logic apply;
	logic servo_on, coasting, clamp_evt;
	vagc_pkg::vagc_state_t st_r, st_nxt;
	logic [2:0][9:0] dac_r;

	always_comb begin
		gain_nxt = gain_r;
		off_nxt = off_r;
		fine_nxt = fine_r;
		filt_nxt = filt_r;
		lta_nxt = lta_r;
		ltb_nxt = ltb_r;
		phase_nxt = phase_r;
		incfg_nxt = incfg_r;
		extclp_nxt = extclp_r;
		sta_nxt = sta_r;
		stb_nxt = stb_r;
		servo_nxt = servo_r;
		gpend_nxt = gpend_r & ~apply;
		if (reg_wr) begin
			unique case (reg_addr)
				`VAGC_A_INCFG: incfg_nxt = reg_wdata;
				`VAGC_A_GAIN0: gain_nxt[0] = reg_wdata;
				`VAGC_A_GAIN1: gain_nxt[1] = reg_wdata;
				`VAGC_A_GAIN2: gain_nxt[2] = reg_wdata;
				`VAGC_A_OFF0: off_nxt[0] = reg_wdata;
				`VAGC_A_OFF1: off_nxt[1] = reg_wdata;
				`VAGC_A_OFF2: off_nxt[2] = reg_wdata;
				`VAGC_A_FINE: fine_nxt = reg_wdata;
				`VAGC_A_FILT: filt_nxt = reg_wdata;
				`VAGC_A_LTA: lta_nxt = reg_wdata;
				`VAGC_A_LTB: ltb_nxt = reg_wdata;
				`VAGC_A_PHASE: phase_nxt = reg_wdata;
				`VAGC_A_EXTCLP: extclp_nxt = reg_wdata;
				`VAGC_A_STA: sta_nxt = reg_wdata;
				`VAGC_A_STB: stb_nxt = reg_wdata;
				`VAGC_A_SERVO: servo_nxt = reg_wdata;
				default: ;
			endcase
			// a write in the apply cycle stays pending: set wins
			if (reg_addr == `VAGC_A_GAIN0 || reg_addr == `VAGC_A_GAIN1 || reg_addr == `VAGC_A_GAIN2) begin
				gpend_nxt = 1'b1;
			end
		end
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`VAGC_A_INCFG: rdata_nxt = incfg_r;
				`VAGC_A_GAIN0: rdata_nxt = gain_r[0];
				`VAGC_A_GAIN1: rdata_nxt = gain_r[1];
				`VAGC_A_GAIN2: rdata_nxt = gain_r[2];
				`VAGC_A_OFF0: rdata_nxt = off_r[0];
				`VAGC_A_OFF1: rdata_nxt = off_r[1];
				`VAGC_A_OFF2: rdata_nxt = off_r[2];
				`VAGC_A_FINE: rdata_nxt = fine_r;
				`VAGC_A_FILT: rdata_nxt = filt_r;
				`VAGC_A_LTA: rdata_nxt = lta_r;
				`VAGC_A_LTB: rdata_nxt = ltb_r;
				`VAGC_A_PHASE: rdata_nxt = phase_r;
				`VAGC_A_EXTCLP: rdata_nxt = extclp_r;
				`VAGC_A_STA: rdata_nxt = sta_r;
				`VAGC_A_STB: rdata_nxt = stb_r;
				`VAGC_A_SERVO: rdata_nxt = servo_r;
				`VAGC_A_STATUS: rdata_nxt = {4'h0, gpend_r, coasting, st_r != vagc_pkg::SV_IDLE, servo_on};
				`VAGC_A_DAC0: rdata_nxt = dac_r[0][9:2];
				`VAGC_A_DAC1: rdata_nxt = dac_r[1][9:2];
				`VAGC_A_DAC2: rdata_nxt = dac_r[2][9:2];
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gain_r <= {3{`VAGC_R_GAIN}};
			off_r <= {3{`VAGC_R_OFF}};
			fine_r <= `VAGC_R_ZERO;
			filt_r <= `VAGC_R_FILT;
			lta_r <= `VAGC_R_LTA;
			ltb_r <= `VAGC_R_LTB;
			phase_r <= `VAGC_R_ZERO;
			incfg_r <= `VAGC_R_ZERO;
			extclp_r <= `VAGC_R_ZERO;
			sta_r <= `VAGC_R_STA;
			stb_r <= `VAGC_R_ZERO;
			servo_r <= `VAGC_R_ZERO;
			rdata_r <= 8'h00;
			gpend_r <= 1'b0;
		end else begin
			gain_r <= gain_nxt;
			off_r <= off_nxt;
			fine_r <= fine_nxt;
			filt_r <= filt_nxt;
			lta_r <= lta_nxt;
			ltb_r <= ltb_nxt;
			phase_r <= phase_nxt;
			incfg_r <= incfg_nxt;
			extclp_r <= extclp_nxt;
			sta_r <= sta_nxt;
			stb_r <= stb_nxt;
			servo_r <= servo_nxt;
			rdata_r <= rdata_nxt;
			gpend_r <= gpend_nxt;
		end
	end
	assign reg_rdata = rdata_r;
	assign servo_on = ~servo_r[`VAGC_B_SERVO_OFF];

	// pin synchronisers: stage 1 feeds stage 2 only
	logic [2:0] sy1_r, sy2_r;
	logic hs_d_r, xc_d_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sy1_r <= 3'h0;
			sy2_r <= 3'h0;
			hs_d_r <= 1'b0;
			xc_d_r <= 1'b0;
		end else begin
			sy1_r <= {ext_clamp_in, coast_in, hsync_in};
			sy2_r <= sy1_r;
			hs_d_r <= sy2_r[0];
			xc_d_r <= sy2_r[2];
		end
	end
	logic hs_trail, ext_clamp_mode, trigger;
	assign coasting = sy2_r[1];
	assign hs_trail = hs_d_r & ~sy2_r[0];
	assign ext_clamp_mode = extclp_r[5:4] != 2'h0;
	assign trigger = hs_trail & (incfg_r[`VAGC_B_COAST_CLP] | ~coasting);

	// black level servo sequencer
	logic [15:0] cnt_r, cnt_nxt, start_cnt;
	logic [6:0] npix;
	logic [2:0][13:0] sum_r, sum_nxt;
	logic [2:0][15:0] acc_r, acc_nxt;
	logic [6:0] lines_r, lines_nxt;
	logic [2:0][9:0] dac_nxt;
	logic [2:0] shift;
	assign start_cnt = {stb_r, sta_r};
	assign shift = 3'(`VAGC_PIX_SHIFT_BASE) + {1'b0, servo_r[3:2]};
	assign npix = 7'(7'h01 << shift);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sum_nxt = sum_r;
		acc_nxt = acc_r;
		lines_nxt = lines_r;
		dac_nxt = dac_r;
		unique case (st_r)
			vagc_pkg::SV_IDLE: begin
				if (trigger) begin
					st_nxt = vagc_pkg::SV_DELAY;
					cnt_nxt = 16'h0000;
				end
			end
			vagc_pkg::SV_DELAY: begin
				if (cnt_r >= start_cnt) begin
					st_nxt = vagc_pkg::SV_SAMPLE;
					cnt_nxt = 16'h0000;
					sum_nxt = '0;
				end else if (adc_in.valid) begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			vagc_pkg::SV_SAMPLE: begin
				if (cnt_r[6:0] == npix) begin
					st_nxt = vagc_pkg::SV_UPDATE;
				end else if (adc_in.valid) begin
					cnt_nxt = cnt_r + 16'h0001;
					for (int c = 0; c < 3; c++) begin
						sum_nxt[c] = sum_r[c] + {6'h00, adc_in.data[c]};
					end
				end
			end
			vagc_pkg::SV_UPDATE: begin
				st_nxt = vagc_pkg::SV_IDLE;
				for (int c = 0; c < 3; c++) begin
					acc_nxt[c] = acc_r[c] + 16'(signed'({2'b00, 8'(sum_r[c] >> shift)})
						- signed'({2'b00, (incfg_r[`VAGC_B_YUV] && c != 1) ? `VAGC_CHROMA_BLACK : 8'h00}));
				end
				lines_nxt = lines_r + 7'h01;
				if (lines_r == 7'(7'h7f >> (3'h7 - servo_r[6:4]))) begin
					lines_nxt = 7'h00;
					for (int c = 0; c < 3; c++) begin
						// quarter-lsb steps keep brightness changes invisible
						if ($signed(acc_nxt[c]) > 0 && dac_r[c] != 10'h000) begin
							dac_nxt[c] = dac_r[c] - 10'h001;
						end else if ($signed(acc_nxt[c]) < 0 && dac_r[c] != `VAGC_DAC_MAX) begin
							dac_nxt[c] = dac_r[c] + 10'h001;
						end
						// cleared only after the sign has steered the step
						acc_nxt[c] = 16'h0000;
					end
				end
				if (!servo_on) begin
					acc_nxt = acc_r;
					lines_nxt = lines_r;
					dac_nxt = dac_r;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= vagc_pkg::SV_IDLE;
			cnt_r <= 16'h0000;
			sum_r <= '0;
			acc_r <= '0;
			lines_r <= 7'h00;
			dac_r <= {3{`VAGC_R_DAC}};
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sum_r <= sum_nxt;
			acc_r <= acc_nxt;
			lines_r <= lines_nxt;
			dac_r <= dac_nxt;
		end
	end
	// internal clamp marks the end of the start delay; external clamp pin otherwise
	assign clamp_evt = ext_clamp_mode ? (sy2_r[2] & ~xc_d_r)
		: (st_r == vagc_pkg::SV_DELAY && st_nxt == vagc_pkg::SV_SAMPLE);

	// gain update: clamp event or timeout
	logic [TMO_W-1:0] tmo_r, tmo_nxt;
	logic [2:0][7:0] gout_r, gout_nxt;
	logic tmo_hit;
	assign tmo_hit = tmo_r == TMO_W'(GAIN_TMO_CYC - 1);
	assign apply = gpend_r & (clamp_evt | tmo_hit);
	always_comb begin
		tmo_nxt = (gpend_r && !apply) ? tmo_r + TMO_W'(1) : '0;
		// code passed unchanged; amplifier maps it
		gout_nxt = apply ? gain_r : gout_r;
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tmo_r <= '0;
			gout_r <= {3{`VAGC_R_GAIN}};
		end else begin
			tmo_r <= tmo_nxt;
			gout_r <= gout_nxt;
		end
	end
	assign gain_code_value = gout_r;

	// offset dac source and digital offset on the sample path
	vagc_pkg::vagc_pix_t pix_r, pix_nxt;
	logic [2:0][9:0] sum_off;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			assign offset_dac[g] = servo_on ? dac_r[g] : {off_r[g], fine_r[7-2*g -: 2]};
			assign sum_off[g] = {2'b00, adc_in.data[g]} + {2'b00, off_r[g]} - 10'h080;
		end
	endgenerate
	always_comb begin
		pix_nxt.valid = adc_in.valid;
		for (int c = 0; c < 3; c++) begin
			if (!servo_on) begin
				pix_nxt.data[c] = adc_in.data[c];
			end else if (sum_off[c][9]) begin
				pix_nxt.data[c] = 8'h00;
			end else if (sum_off[c][8]) begin
				pix_nxt.data[c] = 8'hff;
			end else begin
				pix_nxt.data[c] = sum_off[c][7:0];
			end
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pix_r <= '0;
		end else begin
			pix_r <= pix_nxt;
		end
	end
	assign pix_out = pix_r;

	assign analog_cfg.bw_sel = filt_r[3:1];
	assign analog_cfg.peak_sel = filt_r[7:4];
	assign analog_cfg.dac_half_range = fine_r[`VAGC_B_RANGE];
	assign analog_cfg.line_total_pixels = {ltb_r, lta_r};
	assign analog_cfg.phase = phase_r[5:0];

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_gain_hold: assert property ($changed(gout_r) |-> $past(apply))
		else $error("gain changed without clamp or timeout");
	chk_gain_timeout: assert property (gpend_r && tmo_hit && !$past(reg_wr) |=> gout_r == $past(gain_r))
		else $error("pending gain not applied at timeout");
	chk_bw_field: assert property (reg_wr && reg_addr == `VAGC_A_FILT |=> analog_cfg.bw_sel == $past(reg_wdata[3:1]))
		else $error("bandwidth select not from bits 3..1");
	chk_manual_dac: assert property (!servo_on |-> offset_dac[1] == {off_r[1], fine_r[5:4]})
		else $error("manual dac word wrong");
	chk_coast_block: assert property (st_r == vagc_pkg::SV_IDLE && coasting && !incfg_r[`VAGC_B_COAST_CLP]
		|=> st_r == vagc_pkg::SV_IDLE)
		else $error("servo triggered while coasting");
	chk_delay_count: assert property ($rose(st_r == vagc_pkg::SV_SAMPLE) |-> $past(cnt_r) >= $past(start_cnt))
		else $error("sampling began before start delay");
	chk_dac_step: assert property (servo_on && $changed(dac_r[0])
		|-> (dac_r[0] == $past(dac_r[0]) + 10'h001) || (dac_r[0] == $past(dac_r[0]) - 10'h001))
		else $error("servo dac moved more than one step");
	chk_sat_high: assert property (servo_on && !sum_off[0][9] && sum_off[0][8] |=> pix_out.data[0] == 8'hff)
		else $error("digital offset wrapped high");
	chk_neutral_off: assert property (servo_on && off_r[2] == `VAGC_R_OFF |=> pix_out.data[2] == $past(adc_in.data[2]))
		else $error("neutral offset altered sample");
	cov_servo_line: cover property (st_r == vagc_pkg::SV_SAMPLE ##[1:80] st_r == vagc_pkg::SV_UPDATE);
	cov_gain_clamp: cover property (apply && clamp_evt);
	cov_dac_move: cover property (servo_on && $changed(dac_r[0]));
endmodule : vagc_top
`default_nettype wire

// File: tb/vagc_video_src.sv
// behavioural analog video source: line sync and pixels at the driven level
`timescale 1ns/10ps
`default_nettype none
module vagc_video_src #(
	parameter int LINE = 64,
	parameter int SYNC = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [7:0] level,
	output logic hsync_in,
	output vagc_pkg::vagc_pix_t adc_in
);
	int cnt_r;
	// sync only while running; pixels flow every cycle like a free converter
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 0;
			hsync_in <= 1'b0;
			adc_in <= '0;
		end else begin
			cnt_r <= (cnt_r == LINE - 1) ? 0 : cnt_r + 1;
			hsync_in <= run && (cnt_r < SYNC);
			adc_in.valid <= 1'b1;
			adc_in.data <= {3{level}};
		end
	end
endmodule : vagc_video_src
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench of the video gain/offset control
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic coast_in = 1'b0;
	logic ext_clamp_in = 1'b0;
	logic run = 1'b0;
	logic [7:0] level = 8'h00;
	logic [7:0] reg_rdata;
	logic hsync_in;
	vagc_pkg::vagc_pix_t adc_in;
	vagc_pkg::vagc_pix_t pix_out;
	logic [2:0][7:0] gain_code_value;
	logic [2:0][9:0] offset_dac;
	vagc_pkg::vagc_analog_t analog_cfg;
	int error_cnt = 0;
	int n_compared = 0;
	int i;
	logic [2:0][9:0] snap;
	always #2 clock = ~clock;
	// short gain timeout keeps the no-sync case quick
	vagc_top #(.GAIN_TMO_CYC(200)) DUT (
		.clock(clock),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.hsync_in(hsync_in),
		.coast_in(coast_in),
		.ext_clamp_in(ext_clamp_in),
		.adc_in(adc_in),
		.pix_out(pix_out),
		.gain_code_value(gain_code_value),
		.offset_dac(offset_dac),
		.analog_cfg(analog_cfg)
	);
	vagc_video_src SRC (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(run),
		.level(level),
		.hsync_in(hsync_in),
		.adc_in(adc_in)
	);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		cmp({24'h0, reg_rdata}, {24'h0, exp});
	endtask : rd
	// offsets and source level, then the three output codes
	task automatic px(input logic [7:0] o0, input logic [7:0] o1, input logic [7:0] o2, input logic [7:0] lv,
			input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		wr(8'h09, o0);
		wr(8'h0a, o1);
		wr(8'h0b, o2);
		@(posedge clock);
		level <= lv;
		tick(4);
		cmp({pix_out.valid, pix_out.data}, {1'b1, e2, e1, e0});
	endtask : px
	task automatic summarize;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		tick(1);
		cmp(gain_code_value, {3{8'h55}});
		cmp(offset_dac, {3{10'h200}});
		cmp(analog_cfg, {3'h7, 4'h0, 1'b0, 16'h0320, 6'h00});
		rd(8'h0d, 8'h0e);
		rd(8'h30, 8'h00);
		wr(8'h0d, 8'ha5);
		wr(8'h0e, 8'h34);
		wr(8'h0f, 8'h12);
		wr(8'h10, 8'h3f);
		tick(1);
		cmp(analog_cfg, {3'h2, 4'ha, 1'b0, 16'h1234, 6'h3f});
		rd(8'h0d, 8'ha5);
		// no sync yet: the gain write waits for the timeout
		wr(8'h06, 8'h70);
		tick(100);
		cmp(gain_code_value[0], 8'h55);
		tick(120);
		cmp(gain_code_value, {8'h55, 8'h55, 8'h70});
		@(posedge clock);
		coast_in <= 1'b1;
		level <= 8'h10;
		run <= 1'b1;
		tick(512);
		cmp(offset_dac[0], 10'h200);
		@(posedge clock);
		coast_in <= 1'b0;
		wr(8'h07, 8'h40);
		for (i = 0; i < 100 && gain_code_value[1] !== 8'h40; i++) tick(1);
		cmp(gain_code_value[1], 8'h40);
		if (i == 100) summarize();
		// external clamp mode: internal clamps no longer apply, the pin edge does
		wr(8'h13, 8'h10);
		wr(8'h08, 8'h66);
		tick(100);
		cmp(gain_code_value[2], 8'h55);
		@(posedge clock);
		ext_clamp_in <= 1'b1;
		tick(4);
		cmp(gain_code_value[2], 8'h66);
		@(posedge clock);
		ext_clamp_in <= 1'b0;
		wr(8'h13, 8'h00);
		tick(512);
		cmp(offset_dac[0] !== 10'h200, 32'h1);
		px(8'h90, 8'h80, 8'h00, 8'h05, 8'h15, 8'h05, 8'h00);
		px(8'hff, 8'h81, 8'h7f, 8'hf0, 8'hff, 8'hf1, 8'hef);
		// component mode, coast clamping allowed: chroma aims at mid scale, luma at zero
		wr(8'h05, 8'h24);
		@(posedge clock);
		coast_in <= 1'b1;
		level <= 8'h80;
		tick(130);
		snap = offset_dac;
		tick(256);
		cmp(offset_dac[0], snap[0]);
		cmp(offset_dac[2], snap[2]);
		cmp(10'(snap[1] - offset_dac[1]), 10'h004);
		@(posedge clock);
		coast_in <= 1'b0;
		// manual mode: the digital adder steps aside
		wr(8'h17, 8'h01);
		wr(8'h0c, 8'hc1);
		px(8'h12, 8'h81, 8'h7f, 8'hf0, 8'hf0, 8'hf0, 8'hf0);
		cmp(offset_dac, {10'h1fc, 10'h204, 10'h04b});
		cmp(analog_cfg.dac_half_range, 32'h1);
		summarize();
	end
endmodule : testbench
`default_nettype wire
